// ---- core/hbpwm_top.sv ----
/*
 * Six-input half-bridge PWM control: decoding, lockout windows, sequencing,
 * regulation status, registers and interrupt.
 * Assumes pulse inputs from an outside controller and a plain register port
 * with read data one cycle after the read strobe.
 */
`timescale 1ns/1ns
module hbpwm_top
    import hbpwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [hbpwm_pkg::NIN-1:0] pulse_in,
    input wire logic [hbpwm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hbpwm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hbpwm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [hbpwm_pkg::NB-1:0] meas_strobe,
    input wire logic [hbpwm_pkg::NB-1:0] on_match,
    input wire logic [hbpwm_pkg::NB-1:0] off_match,
    input wire logic [hbpwm_pkg::NB-1:0] on_err_neg,
    input wire logic [hbpwm_pkg::NB-1:0] off_err_neg,
    output logic [hbpwm_pkg::NB-1:0] high_side_switch,
    output logic [hbpwm_pkg::NB-1:0] low_side_switch,
    output logic [hbpwm_pkg::NB-1:0] active_hold_off,
    output logic [hbpwm_pkg::NB-1:0] max_sink_current,
    output logic [hbpwm_pkg::NB-1:0] delay_regulated_flag,
    output logic irq
);
    import hbpwm_pkg::*;

    typedef struct packed {
        hbpwm_phase_t [NB-1:0] phase;
        logic [NB-1:0][TIMER_W-1:0] win;
        logic [NB-1:0][TIMER_W-1:0] freewheel_off_timeout;
        logic [NB-1:0] last_hs;
        logic [NB-1:0] role_hs;
        logic input_count_select;
        logic role_detect_enable;
        logic [1:0] gate_control_scheme;
        logic postcharge_disable;
        logic [NB-1:0] bridge_pulse_enable;
        logic [NB-1:0][1:0] bridge_drive_mode;
        logic [TIMER_W-1:0] ccp_act;
        logic [TIMER_W-1:0] ccp_fw;
        logic [TIMER_W-1:0] freewheel_off_timeout_cfg;
        logic [NB-1:0] hs;
        logic [NB-1:0] ls;
        logic [NB-1:0] hold;
        logic [NB-1:0] sink;
        logic [NB-1:0] regflag;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } hbpwm_state_t;

    hbpwm_state_t q_reg;
    hbpwm_state_t q_next;

    logic [NIN-1:0] pulse_sync;
    logic [NB-1:0] req_hs;
    logic [NB-1:0] req_ls;
    logic [NB-1:0] run;
    logic [NB-1:0] regulated;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    // Two-stage synchroniser
    hbpwm_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(pulse_in),
        .sync_out(pulse_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Per-bridge decoding and regulation tracking
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_bridge
            logic odd_in;
            logic even_in;
            logic mode_hs;
            assign odd_in = pulse_sync[2*g];
            assign even_in = pulse_sync[2*g+1];
            assign mode_hs = (q_reg.bridge_drive_mode[g] == MODE_HS_ACTIVE);
            assign run[g] = q_reg.input_count_select
                            && q_reg.bridge_pulse_enable[g]
                            && ((q_reg.bridge_drive_mode[g] == MODE_LS_ACTIVE)
                                || mode_hs);
            assign req_hs[g] = run[g] && (mode_hs ? (odd_in && !even_in)
                                                  : (even_in && !odd_in));
            assign req_ls[g] = run[g] && (mode_hs ? (even_in && !odd_in)
                                                  : (odd_in && !even_in));
            hbpwm_regul u_regul (
                .clk(clk),
                .rst_b(rst_b),
                .cycle_strobe(meas_strobe[g]),
                .on_match(on_match[g]),
                .off_match(off_match[g]),
                .on_err_neg(on_err_neg[g]),
                .off_err_neg(off_err_neg[g]),
                .regulated(regulated[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic seq_on;
        logic leave_active;
        logic freewheel_off_timeout_zero;
        logic [IRQ_W-1:0] events;
        logic [IRQ_W-1:0] clr;
        seq_on = 1'b0;
        leave_active = 1'b0;
        freewheel_off_timeout_zero = 1'b0;
        events = '0;
        clr = '0;
        q_next = q_reg;
        q_next.sink = '0;
        q_next.rdata = '0;
        // Sequencing only with gate control and post-charge
        seq_on = (q_reg.gate_control_scheme != AGC_OFF)
                 && !q_reg.postcharge_disable;
        for (int b = 0; b < NB; b++) begin
            freewheel_off_timeout_zero = (q_reg.freewheel_off_timeout[b] == TIMER_ZERO);
            if (!freewheel_off_timeout_zero) begin
                q_next.freewheel_off_timeout[b] = q_reg.freewheel_off_timeout[b] - 1'b1;
            end
            if (!q_reg.role_detect_enable) begin
                q_next.role_hs[b] =
                    (q_reg.bridge_drive_mode[b] == MODE_HS_ACTIVE);
            end
            leave_active = q_reg.phase[b] == PH_HS ? q_reg.role_hs[b]
                                                   : !q_reg.role_hs[b];
            if (!run[b]) begin
                q_next.phase[b] = PH_IDLE;
                q_next.hs[b] = 1'b0;
                q_next.ls[b] = 1'b0;
                q_next.win[b] = TIMER_ZERO;
                q_next.freewheel_off_timeout[b] = TIMER_ZERO;
                q_next.hold[b] =
                    (q_reg.bridge_drive_mode[b] == MODE_ACTIVE_OFF);
            end else begin
                q_next.hold[b] = 1'b0;
                case (q_reg.phase[b])
                    PH_IDLE: begin
                        if (req_hs[b]) begin
                            q_next.phase[b] = PH_HS;
                            q_next.hs[b] = 1'b1;
                            q_next.last_hs[b] = 1'b1;
                            // Detection by off-time of other side
                            if (q_reg.role_detect_enable) begin
                                q_next.role_hs[b] = freewheel_off_timeout_zero;
                            end
                            if (!q_reg.last_hs[b] && !freewheel_off_timeout_zero) begin
                                q_next.sink[b] = 1'b1;
                            end
                        end else if (req_ls[b]) begin
                            q_next.phase[b] = PH_LS;
                            q_next.ls[b] = 1'b1;
                            q_next.last_hs[b] = 1'b0;
                            if (q_reg.role_detect_enable) begin
                                q_next.role_hs[b] = !freewheel_off_timeout_zero;
                            end
                        end
                    end
                    PH_HS, PH_LS: begin
                        if ((q_reg.phase[b] == PH_HS) ? !req_hs[b]
                                                      : !req_ls[b]) begin
                            // Switch off before the other turns on
                            q_next.phase[b] = PH_WAIT;
                            q_next.hs[b] = 1'b0;
                            q_next.ls[b] = 1'b0;
                            q_next.freewheel_off_timeout[b] = q_reg.freewheel_off_timeout_cfg;
                            if (!seq_on) begin
                                q_next.win[b] = WIN_MIN;
                            end else if (leave_active) begin
                                q_next.win[b] = q_reg.ccp_act;
                            end else begin
                                q_next.win[b] = q_reg.ccp_fw;
                            end
                            if ((q_reg.phase[b] == PH_HS) ? req_ls[b]
                                                          : req_hs[b]) begin
                                events[IRQ_LOCK_LSB+b] = 1'b1;
                            end
                        end
                    end
                    PH_WAIT: begin
                        // High edge held until window ends
                        // Low edge held until window ends
                        if (q_reg.win[b] <= WIN_MIN) begin
                            q_next.win[b] = TIMER_ZERO;
                            q_next.phase[b] = PH_IDLE;
                        end else begin
                            q_next.win[b] = q_reg.win[b] - 1'b1;
                        end
                    end
                    default: begin
                        q_next.phase[b] = PH_IDLE;
                        q_next.hs[b] = 1'b0;
                        q_next.ls[b] = 1'b0;
                    end
                endcase
            end
            // Flag valid only in adaptive schemes
            q_next.regflag[b] = regulated[b]
                && q_reg.gate_control_scheme[AGC_ADAPTIVE_BIT];
            events[b] = q_next.regflag[b] && !q_reg.regflag[b];
        end

        // Register writes
        if (reg_wr) begin
            if (reg_addr == ADDR_CONFIG) begin
                q_next.input_count_select = reg_wdata[CFG_COUNT_BIT];
                q_next.role_detect_enable = reg_wdata[CFG_ROLE_BIT];
                q_next.gate_control_scheme =
                    reg_wdata[CFG_AGC_LSB +: 2];
                q_next.postcharge_disable = reg_wdata[CFG_POCHG_BIT];
            end else if (reg_addr == ADDR_MODE) begin
                q_next.bridge_pulse_enable = reg_wdata[MODE_EN_LSB +: NB];
                q_next.bridge_drive_mode = reg_wdata[MODE_FIELD_LSB +: 2*NB];
            end else if (reg_addr == ADDR_CCP_ACT) begin
                q_next.ccp_act = reg_wdata[TIMER_W-1:0];
            end else if (reg_addr == ADDR_CCP_FW) begin
                q_next.ccp_fw = reg_wdata[TIMER_W-1:0];
            end else if (reg_addr == ADDR_FREEWHEEL_OFF_TIMEOUT) begin
                q_next.freewheel_off_timeout_cfg = reg_wdata[TIMER_W-1:0];
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                q_next.irq_mask = reg_wdata[IRQ_W-1:0];
            end
        end

        // Register reads; unmapped addresses read zero
        if (reg_rd) begin
            if (reg_addr == ADDR_CONFIG) begin
                q_next.rdata[CFG_COUNT_BIT] = q_reg.input_count_select;
                q_next.rdata[CFG_ROLE_BIT] = q_reg.role_detect_enable;
                q_next.rdata[CFG_AGC_LSB +: 2] = q_reg.gate_control_scheme;
                q_next.rdata[CFG_POCHG_BIT] = q_reg.postcharge_disable;
            end else if (reg_addr == ADDR_MODE) begin
                q_next.rdata[MODE_EN_LSB +: NB] = q_reg.bridge_pulse_enable;
                q_next.rdata[MODE_FIELD_LSB +: 2*NB] = q_reg.bridge_drive_mode;
            end else if (reg_addr == ADDR_CCP_ACT) begin
                q_next.rdata[TIMER_W-1:0] = q_reg.ccp_act;
            end else if (reg_addr == ADDR_CCP_FW) begin
                q_next.rdata[TIMER_W-1:0] = q_reg.ccp_fw;
            end else if (reg_addr == ADDR_FREEWHEEL_OFF_TIMEOUT) begin
                q_next.rdata[TIMER_W-1:0] = q_reg.freewheel_off_timeout_cfg;
            end else if (reg_addr == ADDR_REG_STATUS) begin
                q_next.rdata[NB-1:0] = q_reg.regflag;
            end else if (reg_addr == ADDR_IRQ_STATUS) begin
                q_next.rdata[IRQ_W-1:0] = q_reg.irq_status;
                clr = '1;
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                q_next.rdata[IRQ_W-1:0] = q_reg.irq_mask;
            end
        end

        // Sticky status: a new event wins over the read clear
        q_next.irq_status = (q_reg.irq_status & ~clr) | events;
        q_next.irq = |(q_next.irq_status & q_next.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q_reg <= '0;
            q_reg.phase <= '{default: PH_IDLE};
            q_reg.ccp_act <= CCP_ACT_RST;
            q_reg.ccp_fw <= CCP_FW_RST;
            q_reg.freewheel_off_timeout_cfg <= FREEWHEEL_OFF_TIMEOUT_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = q_reg.rdata;
    assign high_side_switch = q_reg.hs;
    assign low_side_switch = q_reg.ls;
    assign active_hold_off = q_reg.hold;
    assign max_sink_current = q_reg.sink;
    assign delay_regulated_flag = q_reg.regflag;
    assign irq = q_reg.irq;

endmodule : hbpwm_top

// ---- core/hbpwm_pkg.sv ----
/*
 * Constants, register map and types of the six-input half-bridge PWM control.
 * Assumes one 100 MHz clock and a plain word-addressed register port.
 */
package hbpwm_pkg;

    localparam int NB = 3;
    localparam int NIN = 6;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int TIMER_W = 16;
    localparam int CNT_W = 4;
    localparam int ALT_W = 2;
    localparam int IRQ_W = 6;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses (word index)
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CCP_ACT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CCP_FW = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_FREEWHEEL_OFF_TIMEOUT = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_REG_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CFG_COUNT_BIT = 0;
    localparam int CFG_ROLE_BIT = 1;
    localparam int CFG_AGC_LSB = 2;
    localparam int CFG_POCHG_BIT = 4;
    localparam int MODE_EN_LSB = 0;
    localparam int MODE_FIELD_LSB = 4;
    localparam int IRQ_LOCK_LSB = 3;

    ////////////////////////////////////////////////////////////////////////
    // Bridge drive modes and gate control schemes
    localparam logic [1:0] MODE_PASSIVE_OFF = 2'h0;
    localparam logic [1:0] MODE_LS_ACTIVE = 2'h1;
    localparam logic [1:0] MODE_HS_ACTIVE = 2'h2;
    localparam logic [1:0] MODE_ACTIVE_OFF = 2'h3;
    localparam logic [1:0] AGC_OFF = 2'h0;
    localparam int AGC_ADAPTIVE_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and timing counts
    localparam logic [TIMER_W-1:0] CCP_ACT_RST = 16'h0032;
    localparam logic [TIMER_W-1:0] CCP_FW_RST = 16'h0032;
    localparam logic [TIMER_W-1:0] FREEWHEEL_OFF_TIMEOUT_RST = 16'h00C8;
    localparam logic [TIMER_W-1:0] WIN_MIN = 16'h0001;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] REG_THRESH = 4'h8;
    localparam logic [CNT_W-1:0] REG_CNT_MAX = 4'hF;
    localparam logic [CNT_W-1:0] REG_CNT_MIN = 4'h0;
    localparam logic [ALT_W-1:0] SIGN_CHANGES = 2'h3;

    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_HS = 4'b0010,
        PH_LS = 4'b0100,
        PH_WAIT = 4'b1000
    } hbpwm_phase_t;

endpackage : hbpwm_pkg

// ---- core/hbpwm_sync.sv ----
/*
 * Two-stage synchroniser for the six pulse inputs.
 * Assumes inputs may change at any time relative to clk.
 */
`timescale 1ns/1ns
module hbpwm_sync
    import hbpwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [hbpwm_pkg::NIN-1:0] async_in,
    output logic [hbpwm_pkg::NIN-1:0] sync_out
);
    import hbpwm_pkg::*;

    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
    } hbpwm_sync_t;

    hbpwm_sync_t q_reg;
    hbpwm_sync_t q_next;

    always_comb begin
        q_next.s1 = async_in;
        q_next.s2 = q_reg.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign sync_out = q_reg.s2;

endmodule : hbpwm_sync

// ---- core/hbpwm_regul.sv ----
/*
 * Delay regulation tracker of one bridge.
 * Assumes one strobe per PWM cycle with match and error sign of each delay.
 */
`timescale 1ns/1ns
module hbpwm_regul
    import hbpwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cycle_strobe,
    input wire logic on_match,
    input wire logic off_match,
    input wire logic on_err_neg,
    input wire logic off_err_neg,
    output logic regulated
);
    import hbpwm_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] on_cnt;
        logic [CNT_W-1:0] off_cnt;
        logic on_sign;
        logic off_sign;
        logic on_valid;
        logic off_valid;
        logic [ALT_W-1:0] on_alt;
        logic [ALT_W-1:0] off_alt;
        logic regulated;
    } hbpwm_regul_t;

    hbpwm_regul_t q_reg;
    hbpwm_regul_t q_next;

    always_comb begin
        q_next = q_reg;
        if (cycle_strobe) begin
            if (on_match) begin
                if (q_reg.on_cnt != REG_CNT_MAX) begin
                    q_next.on_cnt = q_reg.on_cnt + 1'b1;
                end
            end else if (q_reg.on_cnt != REG_CNT_MIN) begin
                q_next.on_cnt = q_reg.on_cnt - 1'b1;
            end
            if (off_match) begin
                if (q_reg.off_cnt != REG_CNT_MAX) begin
                    q_next.off_cnt = q_reg.off_cnt + 1'b1;
                end
            end else if (q_reg.off_cnt != REG_CNT_MIN) begin
                q_next.off_cnt = q_reg.off_cnt - 1'b1;
            end
            if (on_match) begin
                q_next.on_valid = 1'b0;
                q_next.on_alt = '0;
            end else begin
                q_next.on_valid = 1'b1;
                q_next.on_sign = on_err_neg;
                if (q_reg.on_valid && (on_err_neg != q_reg.on_sign)) begin
                    if (q_reg.on_alt != SIGN_CHANGES) begin
                        q_next.on_alt = q_reg.on_alt + 1'b1;
                    end
                end else begin
                    q_next.on_alt = '0;
                end
            end
            if (off_match) begin
                q_next.off_valid = 1'b0;
                q_next.off_alt = '0;
            end else begin
                q_next.off_valid = 1'b1;
                q_next.off_sign = off_err_neg;
                if (q_reg.off_valid && (off_err_neg != q_reg.off_sign)) begin
                    if (q_reg.off_alt != SIGN_CHANGES) begin
                        q_next.off_alt = q_reg.off_alt + 1'b1;
                    end
                end else begin
                    q_next.off_alt = '0;
                end
            end
        end
        q_next.regulated = ((q_next.on_cnt >= REG_THRESH)
                            && (q_next.off_cnt >= REG_THRESH))
                           || ((q_next.on_alt == SIGN_CHANGES)
                               && (q_next.off_alt == SIGN_CHANGES));
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign regulated = q_reg.regulated;

endmodule : hbpwm_regul

// ---- tb/hbpwm_checker.sv ----
/* Port checks of hbpwm_top.
   Assumes one clock with synchronous active-low reset rst_b. */
`timescale 1ns/1ns
module hbpwm_checker
    import hbpwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NIN-1:0] pulse_in,
    input wire logic [NB-1:0] meas_strobe,
    input wire logic [NB-1:0] high_side_switch,
    input wire logic [NB-1:0] low_side_switch,
    input wire logic [NB-1:0] active_hold_off,
    input wire logic [NB-1:0] max_sink_current,
    input wire logic [NB-1:0] delay_regulated_flag
);
    wire [NB-1:0] hs = high_side_switch;
    wire [NB-1:0] ls = low_side_switch;
    wire [NB-1:0] ms = meas_strobe;
    wire [NB-1:0] fl = delay_regulated_flag;
    wire [NB-1:0] mx = max_sink_current;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Bridges whose two inputs differ
    function automatic logic [2:0] pd(logic [5:0] p);
        return {p[5] ^ p[4], p[3] ^ p[2], p[1] ^ p[0]};
    endfunction : pd
    ////////////////////////////////////////
    sequence s_hs_off; $fell(hs[0]); endsequence
    sequence s_ls_off; $fell(ls[0]); endsequence
    property p_rst_out; $past(!rst_b) |-> (hs | ls | fl) == 3'h0; endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs set after reset");
    property p_excl; (hs & ls) == 3'h0; endproperty
    a_excl: assert property (p_excl)
        else $error("both switches on");
    property p_gap_hl; s_hs_off |-> (!ls[0]) [*2]; endproperty
    a_gap_hl: assert property (p_gap_hl)
        else $error("low side on too soon");
    property p_gap_lh; s_ls_off |-> (!hs[0]) [*2]; endproperty
    a_gap_lh: assert property (p_gap_lh)
        else $error("high side on too soon");
    property p_decode;
        (((hs & ~$past(hs)) | (ls & ~$past(ls))) & ~(pd($past(pulse_in, 2))
            | pd($past(pulse_in, 3)) | pd($past(pulse_in, 4)))) == 3'h0;
    endproperty
    a_decode: assert property (p_decode)
        else $error("switch on without request");
    property p_sink; (mx & $past(mx)) == 3'h0; endproperty
    a_sink: assert property (p_sink)
        else $error("sink pulse too long");
    property p_hold; (active_hold_off & (hs | ls)) == 3'h0; endproperty
    a_hold: assert property (p_hold)
        else $error("held off bridge on");
    property p_flag;
        ((fl & ~$past(fl)) & ~($past(ms) | $past(ms, 2) | $past(ms, 3)
            | $past(ms, 4))) == 3'h0;
    endproperty
    a_flag: assert property (p_flag)
        else $error("flag rose without strobe");
endmodule : hbpwm_checker

// ---- tb/hbpwm_mcu.sv ----
/* Outside controller driving the six pulse pins.
   Assumes the bench gives wanted levels and a lag in cycles. */
`timescale 1ns/1ns
module hbpwm_mcu (
    input wire logic clk,
    input wire logic [5:0] want,
    input wire logic [3:0] lag,
    output logic [5:0] pins
);
    logic [5:0] lvl = 6'h00;
    logic [3:0] cnt = 4'h0;
    assign pins = lvl;
    // Pins follow the wanted levels lag+1 cycles after they differ
    always @(posedge clk) begin
        if (want == lvl) begin
            cnt <= 4'h0;
        end else if (cnt >= lag) begin
            lvl <= want;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : hbpwm_mcu

// ---- tb/tb_hbpwm.sv ----
/* Bench of hbpwm_top: decode, lockout gaps, regulation, interrupt.
   Assumes hbpwm_mcu as pulse source and the checker bound below. */
`timescale 1ns/1ns
module tb_hbpwm;
    import hbpwm_pkg::*;
    logic clk, rst_b, reg_wr, reg_rd, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [NIN-1:0] pulse_in, want;
    logic [3:0] lag;
    logic [NB-1:0] ms, onm, offm, onn, offn, hs, ls, ho, mx, fl;
    int n_errors, cmp_count, n, b;
    // Row: mode, pair (even, odd input), high side, low side
    logic [5:0] rows [10] = '{6'h10, 6'h1A, 6'h15, 6'h1C, 6'h20, 6'h29,
        6'h26, 6'h2C, 6'h08, 6'h34};
    hbpwm_top i_dut (.clk, .rst_b, .pulse_in, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .meas_strobe(ms), .on_match(onm),
        .off_match(offm), .on_err_neg(onn), .off_err_neg(offn),
        .high_side_switch(hs), .low_side_switch(ls), .active_hold_off(ho),
        .max_sink_current(mx), .delay_regulated_flag(fl), .irq);
    hbpwm_mcu i_mcu (.clk, .want, .lag, .pins(pulse_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (e !== g) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic lim(int c, int m);
        if (c >= m) begin
            n_errors++;
            finish_test();
        end
    endtask : lim
    task automatic wr(logic [3:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        step();
        reg_wr <= 1'b0;
        step();
    endtask : wr
    task automatic rd(logic [3:0] a, logic [31:0] e, string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        step();
        reg_rd <= 1'b0;
        chk(nm, e, reg_rdata);
    endtask : rd
    task automatic strb(int k, logic m, logic g);
        ms[k] <= 1'b1;
        {onm, offm, onn, offn} <= {{6{m}}, {6{g}}};
        step();
        ms <= 3'h0;
        repeat (4) step();
    endtask : strb
    // Switch over on bridge 0, count the both-off cycles
    task automatic gap(logic [5:0] a, logic [5:0] z, int w, logic s);
        logic sk;
        sk = 1'b0;
        want <= a;
        repeat (30) step();
        want <= z;
        for (n = 0; n < 20 && (hs[0] | ls[0]) === 1'b1; n++) step();
        lim(n, 20);
        for (n = 0; n < 60 && (hs[0] | ls[0]) === 1'b0; n++) begin
            step();
            sk |= mx[0];
        end
        lim(n, 60);
        step();
        sk |= mx[0];
        chk("gap", w, n);
        chk("sink", {31'h0, s}, {31'h0, sk});
    endtask : gap
    ////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {ms, onm, offm, onn, offn} = '0;
        want = 6'h00;
        lag = 4'h2;
        n_errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_CONFIG, 32'h0, "config");
        rd(ADDR_FREEWHEEL_OFF_TIMEOUT, {16'h0, FREEWHEEL_OFF_TIMEOUT_RST}, "freewheel_off_timeout");
        rd(4'hF, 32'h0, "unmapped");
        wr(ADDR_CCP_ACT, 32'h0000000C);
        wr(ADDR_CCP_FW, 32'h00000004);
        wr(ADDR_CONFIG, 32'h00000009);
        rd(ADDR_CONFIG, 32'h00000009, "config");
        $display("registers done");
        foreach (rows[r]) begin
            for (b = 0; b < NB; b++) begin
                wr(ADDR_MODE, ({30'h0, rows[r][5:4]} << (4 + 2 * b))
                    | 32'h7);
                want <= {4'h0, rows[r][3:2]} << (2 * b);
                repeat (20) step();
                chk("high", {31'h0, rows[r][1]} << b, hs);
                chk("low", {31'h0, rows[r][0]} << b, ls);
                chk("hold", {31'h0, rows[r][5:4] == 2'h3} << b, ho);
                want <= 6'h00;
                repeat (20) step();
            end
        end
        $display("decode done");
        wr(ADDR_MODE, 32'h00000021);
        gap(6'h01, 6'h02, 13, 1'b0);
        gap(6'h02, 6'h01, 5, 1'b1);
        wr(ADDR_MODE, 32'h00000011);
        gap(6'h01, 6'h02, 13, 1'b1);
        gap(6'h02, 6'h01, 5, 1'b0);
        wr(ADDR_CONFIG, 32'h0000000B);
        want <= 6'h00;
        repeat (250) step();
        gap(6'h02, 6'h01, 13, 1'b0);
        wr(ADDR_CONFIG, 32'h00000019);
        gap(6'h01, 6'h02, 2, 1'b1);
        want <= 6'h00;
        $display("lockout done");
        for (b = 0; b < 8; b++) begin
            chk("flag", 32'h0, fl);
            strb(0, 1'b1, 1'b0);
        end
        chk("flag", 32'h1, fl);
        rd(ADDR_REG_STATUS, 32'h1, "regstat");
        chk("irq", 32'h0, irq);
        wr(ADDR_IRQ_MASK, 32'h0000003F);
        chk("irq", 32'h1, irq);
        rd(ADDR_IRQ_STATUS, 32'h9, "irqstat");
        step();
        chk("irq", 32'h0, irq);
        for (b = 0; b < 4; b++) begin
            chk("flag", 32'h1, fl);
            strb(1, 1'b0, b[0]);
        end
        chk("flag", 32'h3, fl);
        chk("irq", 32'h1, irq);
        rd(ADDR_IRQ_STATUS, 32'h2, "irqstat");
        $display("regulation done");
        rst_b <= 1'b0;
        step();
        rst_b <= 1'b1;
        rd(ADDR_CONFIG, 32'h0, "config");
        chk("flag", 32'h0, fl);
        $display("reset done");
        finish_test();
    end
endmodule : tb_hbpwm

bind hbpwm_top hbpwm_checker i_chk (.clk, .rst_b, .pulse_in, .meas_strobe,
    .high_side_switch, .low_side_switch, .active_hold_off,
    .max_sink_current, .delay_regulated_flag);
